//--- design/ctdt_core.sv
// Instruction decode, coprocessor transfer and cycle-type sequencing with AXI4-Lite registers
// Functional notes
// - Execute transfer only when condition passes
// - Coprocessor number selects the responding coprocessor
// - Opcode, register and info fields passed untouched
// - Direction bit set means coprocessor to core
// - Read into PC copies bits 31-28 to flags
// - Write from PC sends PC with flags
// - Undefined class offers, then takes trap
// - Multiply with bit 5/6 set: no trap
// - Counts are incremental, three-stage overlap
// - Data processing, branch, interrupt, trap costs
// - Multiple load/store and memory transfer costs
// - Multiply costs one S plus m internal
// - Coprocessor costs use b busy-wait cycles
// - Failed condition costs exactly one S
// - Unrelated address marks non-sequential cycle
// - Same or next word marks sequential cycle
// - Internal cycle: no transfer, no prefetch
// - Coprocessor cycle exchanges word, memory idle
// - Coprocessor number 0 to 15, others ignored
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module ctdt_core (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic [ctdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ctdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        coproc_absent_line,
  input  wire logic [31:0]                 coproc_data_in,
  output logic [31:0]                      coproc_instr_word,
  output logic                             coproc_offer,
  output logic [31:0]                      coproc_data_out,
  output logic                             coproc_data_oe,
  output logic [1:0]                       bus_cycle_type,
  output logic                             bus_cycle_valid,
  output logic                             undef_trap
);
  import ctdt_pkg::*;

  typedef struct packed {
    ctdt_state_t st;
    logic [1:0]  wait_cnt;
    logic [31:0] instr;
    logic [31:0] operand;
    logic [31:0] pc;
    logic [31:0] mult;
    logic [31:0] result;
    logic [3:0]  result_rd;
    logic [3:0]  flags;
    logic [4:0]  aux_n;
    logic [3:0]  aux_b;
    ctdt_cost_t  left;
    ctdt_cost_t  tot;
    logic        done;
    logic        trapped;
    logic        skipped;
    logic        abs_meta;
    logic        abs_sync;
    logic [31:0] din_meta;
    logic [31:0] din_sync;
    ctdt_cyc_t   cyc_type;
    logic        cyc_valid;
    logic [31:0] cp_instr;
    logic        cp_offer;
    logic [31:0] cp_dout;
    logic        cp_oe;
    logic        trap;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [5:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } ctdt_regs_t;

  ctdt_regs_t  q;
  ctdt_regs_t  d;
  logic        rst_meta_n;
  logic        rst_sync_n;
  logic        go;
  logic        emit_c;
  logic        pass_now;
  ctdt_class_t cls_now;
  ctdt_cost_t  cost_now;

  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic nf;
    logic zf;
    logic cf;
    logic vf;
    nf = f[3];
    zf = f[2];
    cf = f[1];
    vf = f[0];
    unique case (c)
      4'h0: cond_pass = zf;
      4'h1: cond_pass = !zf;
      4'h2: cond_pass = cf;
      4'h3: cond_pass = !cf;
      4'h4: cond_pass = nf;
      4'h5: cond_pass = !nf;
      4'h6: cond_pass = vf;
      4'h7: cond_pass = !vf;
      4'h8: cond_pass = cf && !zf;
      4'h9: cond_pass = !cf || zf;
      4'ha: cond_pass = nf == vf;
      4'hb: cond_pass = nf != vf;
      4'hc: cond_pass = !zf && (nf == vf);
      4'hd: cond_pass = zf || (nf != vf);
      4'he: cond_pass = 1'b1;
      4'hf: cond_pass = 1'b0;
    endcase
  endfunction

  // Multiply with bit 5 or 6 set is not trapped; it falls into data processing
  function automatic ctdt_class_t classify(input logic [31:0] w);
    if (w[27:22] == 6'h00 && w[7:4] == 4'h9) classify = CL_MUL;
    else if (w[27:26] == 2'h0) classify = CL_DP;
    else if (w[27:25] == 3'h3 && w[F_B4]) classify = CL_UNDEF;
    else if (w[27:26] == 2'h1) classify = CL_SDT;
    else if (w[27:25] == 3'h4) classify = CL_BLOCK;
    else if (w[27:25] == 3'h5) classify = CL_BRANCH;
    else if (w[27:25] == 3'h6) classify = CL_CPMEM;
    else if (w[27:24] == 4'hf) classify = CL_SWI;
    else if (w[F_B4]) classify = CL_CPRT;
    else classify = CL_CPDO;
  endfunction

  function automatic logic [7:0] popcount(input logic [15:0] v);
    popcount = 8'h00;
    for (int k = 0; k < 16; k++) begin
      popcount = popcount + {7'h00, v[k]};
    end
  endfunction

  // Smallest m whose range 2^(2m-3)..2^(2m-1)-1 holds the multiplier, capped at the maximum
  function automatic logic [7:0] mul_m(input logic [31:0] rs);
    mul_m = 8'(MUL_MAX);
    for (int k = MUL_MAX; k >= 2; k--) begin
      if ({1'b0, rs} < (33'h1 << (2 * k - 1))) mul_m = 8'(k);
    end
    if (rs <= 32'h1) mul_m = ONE;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int k = 0; k < 4; k++) begin
      merge[8*k +: 8] = s[k] ? n[8*k +: 8] : o[8*k +: 8];
    end
  endfunction

  function automatic ctdt_cost_t class_cost(input ctdt_class_t cl, input logic [31:0] w,
                                            input logic [31:0] rs, input logic [4:0] nw,
                                            input logic [3:0] b);
    logic [7:0] n;
    logic       pcw;
    class_cost = '0;
    pcw = w[F_RD_LO +: 4] == PC_REG;
    unique case (cl)
      CL_DP: begin
        class_cost.s = ONE;
        if (!w[25] && w[F_B4]) class_cost.s = class_cost.s + ONE;
        if (pcw && w[24:23] != 2'h2) begin
          class_cost.s = class_cost.s + ONE;
          class_cost.n = ONE;
        end
      end
      CL_MUL: begin
        class_cost.s = ONE;
        class_cost.i = mul_m(rs);
      end
      CL_SDT: begin
        if (w[F_L]) begin
          class_cost.s = pcw ? TWO : ONE;
          class_cost.n = pcw ? TWO : ONE;
          class_cost.i = ONE;
        end else begin
          class_cost.n = TWO;
        end
      end
      CL_BLOCK: begin
        n = popcount(w[15:0]);
        if (n == 8'h00) n = ONE;
        if (w[F_L]) begin
          class_cost.s = w[F_PCBIT] ? n + ONE : n;
          class_cost.n = w[F_PCBIT] ? TWO : ONE;
          class_cost.i = ONE;
        end else begin
          class_cost.s = n - ONE;
          class_cost.n = TWO;
        end
      end
      CL_CPMEM: begin
        n = (nw == 5'h00) ? ONE : {3'h0, nw};
        class_cost.s = n - ONE;
        class_cost.n = TWO;
        class_cost.i = {4'h0, b};
      end
      CL_CPDO: begin
        class_cost.s = ONE;
        class_cost.i = {4'h0, b};
      end
      CL_CPRT: begin
        class_cost.s = ONE;
        class_cost.i = w[F_L] ? {4'h0, b} : {4'h0, b} + ONE;
        class_cost.c = ONE;
      end
      CL_BRANCH, CL_SWI, CL_UNDEF: begin
        class_cost.s = TWO;
        class_cost.n = ONE;
      end
    endcase
  endfunction

  assign cls_now  = classify(q.instr);
  assign pass_now = cond_pass(q.instr[F_COND_LO +: 4], q.flags);
  assign cost_now = class_cost(cls_now, q.instr, q.mult, q.aux_n, q.aux_b);

  always_comb begin
    d = q;
    go = 1'b0;
    emit_c = 1'b0;
    d.cp_offer = 1'b0;
    d.trap = 1'b0;
    d.cyc_valid = 1'b0;
    d.cp_oe = 1'b0;
    d.abs_meta = coproc_absent_line;
    d.abs_sync = q.abs_meta;
    d.din_meta = coproc_data_in;
    d.din_sync = q.din_meta;
    // Register writes; configuration is frozen while an instruction runs
    if (s_axi_awvalid && q.awready) begin
      d.awready = 1'b0;
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wready = 1'b0;
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      case ({q.awaddr[5:2], 2'h0})
        OFF_CTRL: go = q.wstrb[0] && q.wdata[CTRL_START] && q.st == ST_IDLE;
        OFF_INSTR: if (q.st == ST_IDLE) d.instr = merge(q.instr, q.wdata, q.wstrb);
        OFF_OPERAND: if (q.st == ST_IDLE) d.operand = merge(q.operand, q.wdata, q.wstrb);
        OFF_PC: if (q.st == ST_IDLE) d.pc = merge(q.pc, q.wdata, q.wstrb);
        OFF_MULT: if (q.st == ST_IDLE) d.mult = merge(q.mult, q.wdata, q.wstrb);
        OFF_FLAGS: if (q.st == ST_IDLE && q.wstrb[3]) d.flags = q.wdata[FLAGS_LO +: 4];
        OFF_AUX: begin
          if (q.st == ST_IDLE && q.wstrb[0]) d.aux_n = q.wdata[4:0];
          if (q.st == ST_IDLE && q.wstrb[1]) d.aux_b = q.wdata[AUX_B_LO +: 4];
        end
        OFF_STATUS, OFF_RESULT, OFF_COUNTS: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'h0})
        OFF_CTRL: d.rdata = 32'h0;
        OFF_INSTR: d.rdata = q.instr;
        OFF_OPERAND: d.rdata = q.operand;
        OFF_PC: d.rdata = q.pc;
        OFF_FLAGS: d.rdata = {q.flags, 28'h0};
        OFF_AUX: d.rdata = {20'h0, q.aux_b, 3'h0, q.aux_n};
        OFF_MULT: d.rdata = q.mult;
        OFF_STATUS: d.rdata = {24'h0, q.result_rd, q.skipped, q.trapped, q.done,
                               q.st != ST_IDLE};
        OFF_RESULT: d.rdata = q.result;
        OFF_COUNTS: d.rdata = {q.tot.c, q.tot.i, q.tot.n, q.tot.s};
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    // Sequencer
    unique case (q.st)
      ST_IDLE: begin
        if (go) begin
          d.tot = '0;
          d.done = 1'b0;
          d.trapped = 1'b0;
          d.skipped = 1'b0;
          d.st = ST_EMIT;
          if (!pass_now) begin
            d.left = '0;
            d.left.s = ONE;
            d.skipped = 1'b1;
          end else if (cls_now inside {CL_UNDEF, CL_CPMEM, CL_CPDO, CL_CPRT}) begin
            d.st = ST_OFFER;
          end else begin
            d.left = cost_now;
          end
        end
      end
      ST_OFFER: begin
        d.cp_instr = q.instr;
        d.cp_offer = 1'b1;
        d.wait_cnt = OFFER_WAIT;
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (q.wait_cnt != 2'h0) begin
          d.wait_cnt = q.wait_cnt - 2'h1;
        end else begin
          d.st = ST_EMIT;
          // An absent line still high means nobody took it: trap as undefined
          if (cls_now == CL_UNDEF || q.abs_sync) begin
            d.left = class_cost(CL_UNDEF, q.instr, q.mult, q.aux_n, q.aux_b);
            d.trap = 1'b1;
            d.trapped = 1'b1;
          end else begin
            d.left = cost_now;
          end
        end
      end
      ST_EMIT: begin
        d.cyc_valid = 1'b1;
        if (q.left.s != 8'h00) begin
          d.cyc_type = CYC_S;
          d.left.s = q.left.s - ONE;
          d.tot.s = q.tot.s + ONE;
        end else if (q.left.i != 8'h00) begin
          d.cyc_type = CYC_I;
          d.left.i = q.left.i - ONE;
          d.tot.i = q.tot.i + ONE;
        end else if (q.left.c != 8'h00) begin
          emit_c = 1'b1;
          d.cyc_type = CYC_C;
          d.left.c = q.left.c - ONE;
          d.tot.c = q.tot.c + ONE;
          if (q.instr[F_L]) begin
            if (q.instr[F_RD_LO +: 4] == PC_REG) begin
              d.flags = q.din_sync[FLAGS_LO +: 4];
            end else begin
              d.result = q.din_sync;
              d.result_rd = q.instr[F_RD_LO +: 4];
            end
          end else begin
            d.cp_oe = 1'b1;
            d.cp_dout = (q.instr[F_RD_LO +: 4] == PC_REG) ?
                        {q.flags, q.pc[FLAGS_LO-1:0]} : q.operand;
          end
        end else if (q.left.n != 8'h00) begin
          d.cyc_type = CYC_N;
          d.left.n = q.left.n - ONE;
          d.tot.n = q.tot.n + ONE;
        end else begin
          d.cyc_valid = 1'b0;
          d.done = 1'b1;
          d.st = ST_IDLE;
        end
      end
    endcase
  end

  // Reset is applied at once but released only after two clock edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cyc_type <= CYC_N;
      q.flags <= FLAGS_RST;
      q.abs_meta <= 1'b1;
      q.abs_sync <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready     = q.awready;
  assign s_axi_wready      = q.wready;
  assign s_axi_bresp       = q.bresp;
  assign s_axi_bvalid      = q.bvalid;
  assign s_axi_arready     = q.arready;
  assign s_axi_rdata       = q.rdata;
  assign s_axi_rresp       = q.rresp;
  assign s_axi_rvalid      = q.rvalid;
  assign coproc_instr_word = q.cp_instr;
  assign coproc_offer      = q.cp_offer;
  assign coproc_data_out   = q.cp_dout;
  assign coproc_data_oe    = q.cp_oe;
  assign bus_cycle_type    = q.cyc_type;
  assign bus_cycle_valid   = q.cyc_valid;
  assign undef_trap        = q.trap;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_one_s_end;
    (q.cyc_valid && q.cyc_type == CYC_S) ##1 !q.cyc_valid;
  endsequence
  sequence s_two_s_one_n;
    (q.cyc_valid && q.cyc_type == CYC_S) ##1 (q.cyc_valid && q.cyc_type == CYC_S)
      ##1 (q.cyc_valid && q.cyc_type == CYC_N) ##1 !q.cyc_valid;
  endsequence

  chk_skip_one_s: assert property (go && !pass_now |-> ##2 s_one_s_end)
    else $error("failed condition did not cost one S cycle");
  chk_skip_no_offer: assert property (go && !pass_now |-> ##1 (!q.cp_offer)[*3])
    else $error("skipped instruction was offered to a coprocessor");
  chk_branch_cost: assert property (go && pass_now && cls_now == CL_BRANCH |->
    ##2 s_two_s_one_n)
    else $error("branch did not cost two S and one N");
  chk_mul_small: assert property (go && pass_now && cls_now == CL_MUL &&
    q.mult == 32'h0 |->
    ##2 (q.cyc_type == CYC_S && q.cyc_valid) ##1 (q.cyc_type == CYC_I && q.cyc_valid)
    ##1 !q.cyc_valid)
    else $error("multiply by zero did not cost one S and one I");
  chk_trap_offered: assert property (q.trap |-> $past(q.cp_offer, 4))
    else $error("trap taken without offering to coprocessors");
  chk_pc_flags: assert property (emit_c && q.instr[F_L] && q.instr[F_RD_LO +: 4] == PC_REG |=>
    q.flags == $past(q.din_sync[31:28]) && $stable(q.pc) && $stable(q.result))
    else $error("read into PC did not load flags only");
  chk_pc_source: assert property (emit_c && !q.instr[F_L] && q.instr[F_RD_LO +: 4] == PC_REG |=>
    q.cp_oe && q.cp_dout == {$past(q.flags), $past(q.pc[27:0])})
    else $error("write from PC did not send PC with flags");
  chk_read_dir: assert property (emit_c && q.instr[F_L] && q.instr[F_RD_LO +: 4] != PC_REG |=>
    !q.cp_oe && q.result == $past(q.din_sync))
    else $error("coprocessor read did not land in result");
  chk_oe_in_c: assert property (q.cp_oe |-> q.cyc_valid && q.cyc_type == CYC_C)
    else $error("data driven outside a coprocessor cycle");
  chk_offer_word: assert property (q.cp_offer |-> q.cp_instr == q.instr)
    else $error("offered word differs from the decoded instruction");
endmodule

//--- inc/ctdt_pkg.sv
// Shared constants and types of the coprocessor transfer decode and timing block
package ctdt_pkg;
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  OFF_CTRL    = 6'h00;
  localparam logic [5:0]  OFF_INSTR   = 6'h04;
  localparam logic [5:0]  OFF_OPERAND = 6'h08;
  localparam logic [5:0]  OFF_PC      = 6'h0c;
  localparam logic [5:0]  OFF_FLAGS   = 6'h10;
  localparam logic [5:0]  OFF_AUX     = 6'h14;
  localparam logic [5:0]  OFF_MULT    = 6'h18;
  localparam logic [5:0]  OFF_STATUS  = 6'h1c;
  localparam logic [5:0]  OFF_RESULT  = 6'h20;
  localparam logic [5:0]  OFF_COUNTS  = 6'h24;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int unsigned CTRL_START  = 0;
  // Instruction and register field positions, then fixed values
  localparam int unsigned F_COND_LO   = 28;
  localparam int unsigned F_L         = 20;
  localparam int unsigned F_RD_LO     = 12;
  localparam int unsigned F_B4        = 4;
  localparam int unsigned F_PCBIT     = 15;
  localparam int unsigned FLAGS_LO    = 28;
  localparam int unsigned AUX_B_LO    = 8;
  localparam logic [3:0]  PC_REG      = 4'hf;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;
  localparam logic [1:0]  OFFER_WAIT  = 2'h3;
  localparam int unsigned MUL_MAX     = 16;
  localparam logic [7:0]  ONE         = 8'h01;
  localparam logic [7:0]  TWO         = 8'h02;

  typedef enum logic [1:0] {CYC_N, CYC_S, CYC_I, CYC_C} ctdt_cyc_t;
  typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_WAIT, ST_EMIT} ctdt_state_t;
  typedef enum logic [3:0] {
    CL_DP, CL_MUL, CL_SDT, CL_UNDEF, CL_BLOCK, CL_BRANCH, CL_CPMEM, CL_CPDO, CL_CPRT, CL_SWI
  } ctdt_class_t;
  typedef struct packed {
    logic [7:0] s;
    logic [7:0] n;
    logic [7:0] i;
    logic [7:0] c;
  } ctdt_cost_t;
endpackage

//--- sim/coproc_transfer_decode_timing_bench.sv
// Self-checking bench: registers, coprocessor transfers, traps and cycle costs
`timescale 1ns/100ps
module coproc_transfer_decode_timing_bench;
  import ctdt_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, coproc_data_in, coproc_instr_word, coproc_data_out;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, bus_cycle_type, rr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              coproc_absent_line, coproc_offer, coproc_data_oe, bus_cycle_valid, undef_trap;
  int                n_fail, total_checks, traps, offers;
  ctdt_cost_t        seen;
  logic [31:0]       offered_w, oe_word, rd;
  localparam logic [31:0] COST_TAB [12] = '{32'hef000000, 32'h02010000, 32'he1a0f211,
    32'h03010000, 32'he8900007, 32'h03010100, 32'he8800007, 32'h02020000, 32'hed915500,
    32'h02020200, 32'hee123541, 32'h01000200};

  ctdt_core DUT (.*);
  ctdt_coproc_model PEER (.*);

  always #12.5 core_clk = ~core_clk;

  // One clock serves every cycle type, which keeps I,C no slower than S, S no slower than N
  always @(posedge core_clk) begin
    if (bus_cycle_valid) begin
      case (ctdt_cyc_t'(bus_cycle_type))
        CYC_N: seen.n <= seen.n + ONE;
        CYC_S: seen.s <= seen.s + ONE;
        CYC_I: seen.i <= seen.i + ONE;
        default: seen.c <= seen.c + ONE;
      endcase
    end
    if (undef_trap) traps <= traps + 1;
    if (coproc_offer) begin
      offers <= offers + 1;
      offered_w <= coproc_instr_word;
    end
    if (coproc_data_oe) oe_word <= coproc_data_out;
  end

  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask

  task test_done;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task hang(input string w);
    n_fail++;
    $display("Error %s expected answer seen none", w);
    test_done;
  endtask

  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 40) hang("write response");
    check("write response", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic axr(input logic [5:0] a);
    int k;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    if (k == 40) hang("read response");
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] e, input string w);
    axr(a);
    check(w, e, rd);
  endtask

  // Runs one instruction to completion and compares its S, N, I and C counts
  task automatic exec(input logic [31:0] ins, input logic [31:0] cost, input int t);
    int k;
    axw(OFF_INSTR, ins, RESP_OKAY);
    @(negedge core_clk);
    seen = '0;
    traps = 0;
    offers = 0;
    axw(OFF_CTRL, 32'h1, RESP_OKAY);
    for (k = 0; k < 60; k++) begin
      axr(OFF_STATUS);
      if (rd[0] === 1'b0) break;
    end
    if (k == 60) hang("instruction end");
    check("cycle counts", cost, seen);
    rchk(OFF_COUNTS, {cost[7:0], cost[15:8], cost[23:16], cost[31:24]}, "count register");
    check("trap pulses", t, traps);
  endtask

  task t_regs;
    rchk(6'h3c, 32'h0, "unmapped read data");
    check("unmapped read response", {30'h0, RESP_SLVERR}, {30'h0, rr});
    axw(6'h38, 32'h0, RESP_SLVERR);
    axw(OFF_PC, 32'h00001238, RESP_OKAY);
    axw(OFF_FLAGS, 32'h0, RESP_OKAY);
    axw(OFF_AUX, 32'h0, RESP_OKAY);
    axw(OFF_STATUS, 32'hf0, RESP_OKAY);
    rchk(OFF_STATUS, 32'h0, "status after read-only write");
    $display("Test registers done");
  endtask

  task t_cond;
    exec(32'h0a000000, 32'h01000000, 0);
    rchk(OFF_STATUS, 32'h0000000a, "skipped status");
    exec(32'h0e32f531, 32'h01000000, 0);
    check("offers on failed condition", 32'h0, offers);
    exec(32'h1a000000, 32'h02010000, 0);
    $display("Test conditions done");
  endtask

  task t_xfer;
    exec(32'hee323531, 32'h01000001, 0);
    rchk(OFF_RESULT, 32'ha5a51234, "read word");
    rchk(OFF_FLAGS, 32'h0, "flags after plain read");
    exec(32'hee32f531, 32'h01000001, 0);
    check("offered word", 32'hee32f531, offered_w);
    rchk(OFF_FLAGS, 32'ha0000000, "flags");
    rchk(OFF_PC, 32'h00001238, "pc");
    axw(OFF_AUX, 32'h00000203, RESP_OKAY);
    exec(32'hee22f531, 32'h01000301, 0);
    check("pc write word", 32'ha0001238, oe_word);
    axw(OFF_OPERAND, 32'h5a5a0f0f, RESP_OKAY);
    exec(32'hee223531, 32'h01000301, 0);
    check("operand write word", 32'h5a5a0f0f, oe_word);
    $display("Test transfers done");
  endtask

  task t_trap;
    exec(32'he6000010, 32'h02010000, 1);
    check("offers", 32'h1, offers);
    exec(32'hee323631, 32'h02010000, 1);
    exec(32'he00002b1, 32'h02000000, 0);
    check("offers on near multiply", 32'h0, offers);
    $display("Test traps done");
  endtask

  task t_costs;
    logic [31:0] mv [5];
    logic [7:0]  mm [5];
    mv = '{32'h0, 32'h1, 32'h7, 32'h8, 32'h20000000};
    mm = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h10};
    for (int k = 0; k < 12; k += 2) begin
      exec(COST_TAB[k], COST_TAB[k+1], 0);
    end
    for (int k = 0; k < 5; k++) begin
      axw(OFF_MULT, mv[k], RESP_OKAY);
      exec(32'he0000291, {8'h01, 8'h00, mm[k], 8'h00}, 0);
    end
    $display("Test costs done");
  endtask

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs;
    t_cond;
    t_xfer;
    t_trap;
    t_costs;
    test_done;
  end
endmodule

//--- sim/ctdt_coproc_model.sv
// Behavioural coprocessor that claims coprocessor instructions carrying its own number
`timescale 1ns/100ps
module ctdt_coproc_model #(
  parameter logic [3:0]  CP_NUM    = 4'h5,
  parameter logic [31:0] READ_WORD = 32'ha5a51234
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] coproc_instr_word,
  input  wire logic        coproc_offer,
  output logic             coproc_absent_line,
  output logic [31:0]      coproc_data_in
);
  logic engaged_q;
  logic claim;
  logic active;
  // Undefined class never matches, so the line is left pulled high for it
  assign claim = (coproc_instr_word[27:25] == 3'h6 || coproc_instr_word[27:24] == 4'he)
                 && coproc_instr_word[11:8] == CP_NUM;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      engaged_q <= 1'b0;
    end else if (coproc_offer) begin
      engaged_q <= 1'b1;
    end
  end
  assign active = claim && (coproc_offer || engaged_q);
  // Busy-wait is never requested here, the core's b setting stands in for it
  assign coproc_absent_line = !active;
  // Released bus shows the inverse so a stale capture cannot pass
  assign coproc_data_in = active ? READ_WORD : ~READ_WORD;
endmodule
